/* File: design/lpe_clk_div.sv */
// enable-pulse divider for the bus clock and the serial bit rate
`timescale 1ns/1ps
module lpe_clk_div
    import lpe_pkg::*;
#(
    parameter int unsigned DIV = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic tick_o
);

    localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic tick_nxt;

    // counter restarts when halted so the first tick is a full period away
    always_comb begin
        cnt_nxt = '0;
        tick_nxt = 1'b0;
        if (run_i) begin
            if (cnt_r == LAST) begin
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end

endmodule : lpe_clk_div

/* File: design/lpe_pkg.sv */
// constants, types and helpers for the low power entry side-effect block
// Functional notes
// R1: deep standby only when wait runs with both standby selects set
// R2: software stops dma and transfer units before clock stop or standby
// R3: bus clock halts high in standby modes, keeps running in sleep/clock stop
// R4: bus clock output stop bit forces the bus clock pin high
// R5: dac in module stop or standby keeps outputs and conversion current
// R6: software clears dac enables first to cut analog current
// R7: deep standby puts the dac output pin in high impedance
// R8: software clears adc start before module stop to cut current
// R9: software clears serial enables before module stop or standby
// R10: transmit enable at 0 resets shift, holding and status registers
// R11: serial pins follow port while stopped, drive high when cancelled
// R12: character in transmission at low power entry is undetermined
// R13: character in reception at low power entry is dropped as invalid
// R14: side effects apply at the wait transition, not at bit writes
package lpe_pkg;

    localparam int unsigned BCLK_DIV = 2;
    localparam int unsigned BAUD_DIV = 16;
    localparam int unsigned DIV_W = 8;
    localparam int unsigned DAC_W = 8;
    localparam int unsigned SCI_W = 8;
    localparam logic [3:0] RX_LAST_BIT = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    typedef enum logic [4:0] {
        PM_RUN = 5'h01,
        PM_SLEEP = 5'h02,
        PM_ALLSTOP = 5'h04,
        PM_SWSTBY = 5'h08,
        PM_DEEP = 5'h10
    } lpe_pm_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'h1,
        SH_BUSY = 2'h2
    } lpe_sh_t;

    typedef struct packed {
        logic tx_interrupt_on;
        logic transmit_enable;
        logic rx_on;
        logic tx_end_irq_on;
    } lpe_sci_ctrl_t;

    typedef struct packed {
        logic tx_empty;
        logic tx_end;
        logic rx_full;
        logic frame_err;
    } lpe_sci_stat_t;

    localparam lpe_sci_stat_t SCI_STAT_RST = '{
        tx_empty: 1'b1, tx_end: 1'b1, rx_full: 1'b0, frame_err: 1'b0};

    typedef struct packed {
        logic dac_output_enable_1;
        logic dac_output_enable_0;
        logic dac_joint_enable;
    } lpe_dac_ctrl_t;

    // mode chosen by a wait instruction
    function automatic lpe_pm_t lpe_wait_target(input logic standby_select,
                                                input logic deep_standby_select,
                                                input logic allstop);
        if (standby_select && deep_standby_select) begin
            return PM_DEEP; // R1
        end else if (standby_select) begin
            return PM_SWSTBY;
        end else if (allstop) begin
            return PM_ALLSTOP;
        end
        return PM_SLEEP;
    endfunction : lpe_wait_target

    function automatic logic lpe_is_standby(input lpe_pm_t pm);
        return (pm == PM_SWSTBY) || (pm == PM_DEEP);
    endfunction : lpe_is_standby

endpackage : lpe_pkg

/* File: design/lpe_top.sv */
// low power mode sequencer with bus clock, converter and serial effects
`timescale 1ns/1ps
module lpe_top
    import lpe_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wait_exec_i,
    input wire logic wake_i,
    input wire logic standby_select_i,
    input wire logic deep_standby_select_i,
    input wire logic all_module_stop_select_i,
    input wire logic ext_bus_enable_i,
    input wire logic bus_clock_output_stop_i,
    input wire lpe_dac_ctrl_t dac_ctrl_i,
    input wire logic dac_module_stop_i,
    input wire logic [DAC_W-1:0] dac_data_0_i,
    input wire logic [DAC_W-1:0] dac_data_1_i,
    input wire logic adc_conversion_start_i,
    input wire logic adc_module_stop_i,
    input wire lpe_sci_ctrl_t sci_ctrl_i,
    input wire logic sci_module_stop_i,
    input wire logic [SCI_W-1:0] tx_data_i,
    input wire logic tx_write_i,
    input wire logic rx_read_i,
    input wire logic rxd_i,
    input wire logic port_txd_level_i,
    output lpe_pm_t mode_o,
    output logic external_bus_clock_o,
    output logic [DAC_W-1:0] dac_out_0_o,
    output logic [DAC_W-1:0] dac_out_1_o,
    output logic dac_oe_0_o,
    output logic dac_oe_1_o,
    output logic dac_analog_current_o,
    output logic adc_analog_current_o,
    output logic txd_o,
    output logic [SCI_W-1:0] rx_data_o,
    output logic rx_valid_o,
    output lpe_sci_stat_t serial_status_o
);

    ////////////////////////////////////////////////////////////////////////
    // power mode

    lpe_pm_t pm_r;
    lpe_pm_t pm_nxt;
    logic lp_entry;

    // the control bits are only sampled here, at the wait itself
    always_comb begin
        pm_nxt = pm_r;
        lp_entry = 1'b0;
        case (pm_r)
            PM_RUN: begin
                if (wait_exec_i) begin
                    lp_entry = 1'b1; // R14
                    pm_nxt = lpe_wait_target(standby_select_i,
                        deep_standby_select_i, all_module_stop_select_i); // R1
                end
            end
            PM_SLEEP, PM_ALLSTOP, PM_SWSTBY, PM_DEEP: begin
                if (wake_i) begin
                    pm_nxt = PM_RUN;
                end
            end
            default: begin
                pm_nxt = PM_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pm_r <= PM_RUN;
        end else begin
            pm_r <= pm_nxt;
        end
    end

    assign mode_o = pm_r;

    ////////////////////////////////////////////////////////////////////////
    // external bus clock

    logic bclk_run;
    logic bclk_tick;
    logic bclk_r;
    logic bclk_nxt;

    assign bclk_run = ext_bus_enable_i && !bus_clock_output_stop_i &&
        !lpe_is_standby(pm_r); // R3

    lpe_clk_div #(.DIV(BCLK_DIV)) u_bclk_div (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(bclk_run),
        .tick_o(bclk_tick)
    );

    // parked high rather than low so the pin idles at its stop level
    always_comb begin
        bclk_nxt = bclk_r;
        if (!bclk_run) begin
            bclk_nxt = 1'b1; // R4
        end else if (bclk_tick) begin
            bclk_nxt = !bclk_r; // R3
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bclk_r <= 1'b1;
        end else begin
            bclk_r <= bclk_nxt;
        end
    end

    assign external_bus_clock_o = bclk_r;

    ////////////////////////////////////////////////////////////////////////
    // converters

    logic dac_frozen;
    logic [DAC_W-1:0] dac_0_nxt;
    logic [DAC_W-1:0] dac_1_nxt;
    logic dac_oe_0_nxt;
    logic dac_oe_1_nxt;
    logic dac_cur_nxt;
    logic adc_cur_nxt;
    logic dac_any;

    assign dac_frozen = dac_module_stop_i || (pm_r != PM_RUN &&
        pm_r != PM_SLEEP);
    assign dac_any = dac_ctrl_i.dac_output_enable_0 ||
        dac_ctrl_i.dac_output_enable_1 || dac_ctrl_i.dac_joint_enable;

    always_comb begin
        dac_0_nxt = dac_out_0_o;
        dac_1_nxt = dac_out_1_o;
        if (!dac_frozen) begin
            dac_0_nxt = dac_data_0_i;
            dac_1_nxt = dac_data_1_i;
        end
        // R5 holds the values above while frozen
        dac_oe_0_nxt = dac_ctrl_i.dac_output_enable_0 && pm_r != PM_DEEP; // R7
        dac_oe_1_nxt = dac_ctrl_i.dac_output_enable_1 && pm_r != PM_DEEP; // R7
        dac_cur_nxt = dac_any && pm_r != PM_DEEP; // R5
        // current stays while start is set outside deep standby, module stop or not
        adc_cur_nxt = adc_conversion_start_i && pm_r != PM_DEEP;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dac_out_0_o <= '0;
            dac_out_1_o <= '0;
            dac_oe_0_o <= 1'b0;
            dac_oe_1_o <= 1'b0;
            dac_analog_current_o <= 1'b0;
            adc_analog_current_o <= 1'b0;
        end else begin
            dac_out_0_o <= dac_0_nxt;
            dac_out_1_o <= dac_1_nxt;
            dac_oe_0_o <= dac_oe_0_nxt;
            dac_oe_1_o <= dac_oe_1_nxt;
            dac_analog_current_o <= dac_cur_nxt;
            adc_analog_current_o <= adc_cur_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial unit

    logic sci_stop;
    logic baud_tick;
    lpe_sh_t tx_st_r;
    lpe_sh_t tx_st_nxt;
    lpe_sh_t rx_st_r;
    lpe_sh_t rx_st_nxt;
    logic [SCI_W+1:0] tx_shift_r;
    logic [SCI_W+1:0] tx_shift_nxt;
    logic [SCI_W-1:0] tx_hold_r;
    logic [SCI_W-1:0] tx_hold_nxt;
    logic [3:0] tx_cnt_r;
    logic [3:0] tx_cnt_nxt;
    logic [SCI_W-1:0] rx_shift_r;
    logic [SCI_W-1:0] rx_shift_nxt;
    logic [3:0] rx_cnt_r;
    logic [3:0] rx_cnt_nxt;
    lpe_sci_stat_t stat_r;
    lpe_sci_stat_t stat_nxt;
    logic [SCI_W-1:0] rx_data_nxt;
    logic rx_valid_nxt;
    logic txd_nxt;

    assign sci_stop = sci_module_stop_i || (pm_r != PM_RUN &&
        pm_r != PM_SLEEP);

    lpe_clk_div #(.DIV(BAUD_DIV)) u_baud_div (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .run_i(!sci_stop),
        .tick_o(baud_tick)
    );

    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_shift_nxt = tx_shift_r;
        tx_hold_nxt = tx_hold_r;
        tx_cnt_nxt = tx_cnt_r;
        rx_st_nxt = rx_st_r;
        rx_shift_nxt = rx_shift_r;
        rx_cnt_nxt = rx_cnt_r;
        stat_nxt = stat_r;
        rx_data_nxt = rx_data_o;
        rx_valid_nxt = 1'b0;
        if (rx_read_i) begin
            stat_nxt.rx_full = 1'b0;
        end
        if (tx_write_i && stat_r.tx_empty) begin
            tx_hold_nxt = tx_data_i;
            stat_nxt.tx_empty = 1'b0;
            stat_nxt.tx_end = 1'b0;
        end
        case (tx_st_r)
            SH_IDLE: begin
                if (!stat_r.tx_empty && !sci_stop) begin
                    tx_shift_nxt = {1'b1, tx_hold_r, 1'b0};
                    tx_cnt_nxt = BIT_CNT_RST;
                    stat_nxt.tx_empty = 1'b1;
                    tx_st_nxt = SH_BUSY;
                end
            end
            SH_BUSY: begin
                if (baud_tick) begin
                    tx_shift_nxt = {1'b1, tx_shift_r[SCI_W+1:1]};
                    tx_cnt_nxt = tx_cnt_r + 1'b1;
                    if (tx_cnt_r == TX_LAST_BIT) begin
                        tx_st_nxt = SH_IDLE;
                        stat_nxt.tx_end = stat_nxt.tx_empty;
                    end
                end
            end
            default: begin
                tx_st_nxt = SH_IDLE;
            end
        endcase
        case (rx_st_r)
            SH_IDLE: begin
                if (baud_tick && sci_ctrl_i.rx_on && !rxd_i) begin
                    rx_cnt_nxt = BIT_CNT_RST;
                    rx_st_nxt = SH_BUSY;
                end
            end
            SH_BUSY: begin
                if (baud_tick) begin
                    rx_cnt_nxt = rx_cnt_r + 1'b1;
                    if (rx_cnt_r == RX_LAST_BIT) begin
                        rx_st_nxt = SH_IDLE;
                        if (rxd_i) begin
                            rx_data_nxt = rx_shift_r;
                            rx_valid_nxt = 1'b1;
                            stat_nxt.rx_full = 1'b1;
                        end else begin
                            stat_nxt.frame_err = 1'b1;
                        end
                    end else begin
                        rx_shift_nxt = {rxd_i, rx_shift_r[SCI_W-1:1]};
                    end
                end
            end
            default: begin
                rx_st_nxt = SH_IDLE;
            end
        endcase
        // partial character abandoned, its value is not kept
        if (lp_entry) begin
            tx_st_nxt = SH_IDLE; // R12
            rx_st_nxt = SH_IDLE; // R13
            rx_valid_nxt = 1'b0; // R13
            rx_data_nxt = rx_data_o; // R13
            stat_nxt.rx_full = stat_r.rx_full && !rx_read_i; // R13
            stat_nxt.frame_err = stat_r.frame_err; // R13
        end
        if (!sci_ctrl_i.transmit_enable) begin
            tx_st_nxt = SH_IDLE; // R10
            tx_shift_nxt = '1; // R10
            tx_hold_nxt = '0; // R10
            stat_nxt = SCI_STAT_RST; // R10
        end
        // stopped: port owns the pin; on cancel the idle line is high
        if (sci_stop) begin
            txd_nxt = port_txd_level_i; // R11
        end else if (tx_st_nxt == SH_BUSY) begin
            txd_nxt = tx_shift_nxt[0];
        end else begin
            txd_nxt = 1'b1; // R11
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_st_r <= SH_IDLE;
            rx_st_r <= SH_IDLE;
            tx_shift_r <= '1;
            tx_hold_r <= '0;
            tx_cnt_r <= BIT_CNT_RST;
            rx_shift_r <= '0;
            rx_cnt_r <= BIT_CNT_RST;
            stat_r <= SCI_STAT_RST;
            rx_data_o <= '0;
            rx_valid_o <= 1'b0;
            txd_o <= 1'b1;
        end else begin
            tx_st_r <= tx_st_nxt;
            rx_st_r <= rx_st_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_hold_r <= tx_hold_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            stat_r <= stat_nxt;
            rx_data_o <= rx_data_nxt;
            rx_valid_o <= rx_valid_nxt;
            txd_o <= txd_nxt;
        end
    end

    assign serial_status_o = stat_r;

endmodule : lpe_top

/* File: verif/lpe_top_monitor.sv */
// assertion checker for the low power entry block
`timescale 1ns/1ps
module lpe_top_monitor
    import lpe_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wait_exec_i,
    input wire logic standby_select_i,
    input wire logic deep_standby_select_i,
    input wire logic ext_bus_enable_i,
    input wire logic bus_clock_output_stop_i,
    input wire lpe_dac_ctrl_t dac_ctrl_i,
    input wire lpe_sci_ctrl_t sci_ctrl_i,
    input wire logic sci_module_stop_i,
    input wire logic port_txd_level_i,
    input wire lpe_pm_t mode_o,
    input wire logic external_bus_clock_o,
    input wire logic [DAC_W-1:0] dac_out_0_o,
    input wire logic dac_oe_0_o,
    input wire logic dac_analog_current_o,
    input wire logic txd_o,
    input wire lpe_sci_stat_t serial_status_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic sb;
    logic run_bc;
    assign sb = (mode_o == PM_SWSTBY) || (mode_o == PM_DEEP);
    assign run_bc = ext_bus_enable_i && !bus_clock_output_stop_i && !sb;
    ////////////////////////////////////////
    property p_deep;
        mode_o == PM_RUN && wait_exec_i && standby_select_i
            && deep_standby_select_i |=> mode_o == PM_DEEP;
    endproperty
    a_deep: assert property (p_deep) else $error("deep entry");
    property p_swsb;
        mode_o == PM_RUN && wait_exec_i && standby_select_i
            && !deep_standby_select_i |=> mode_o == PM_SWSTBY;
    endproperty
    a_swsb: assert property (p_swsb) else $error("standby entry");
    property p_sb_high; sb [*2] |-> external_bus_clock_o; endproperty
    a_sb_high: assert property (p_sb_high) else $error("bclk low");
    // six cycles let the divider restart before the period is judged
    property p_bclk_run;
        run_bc [*6] |-> external_bus_clock_o != $past(external_bus_clock_o, 2);
    endproperty
    a_bclk_run: assert property (p_bclk_run) else $error("bclk stuck");
    property p_pstop; bus_clock_output_stop_i |=> external_bus_clock_o;
    endproperty
    a_pstop: assert property (p_pstop) else $error("bclk not high");
    property p_freeze;
        mode_o inside {PM_ALLSTOP, PM_SWSTBY, PM_DEEP}
            |=> $stable(dac_out_0_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("dac moved");
    property p_dac_hold;
        mode_o == PM_SWSTBY && dac_ctrl_i.dac_joint_enable
            |=> dac_analog_current_o;
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("dac current");
    property p_hiz;
        mode_o == PM_DEEP |=> !dac_oe_0_o && !dac_analog_current_o;
    endproperty
    a_hiz: assert property (p_hiz) else $error("dac driven");
    property p_te_rst;
        !sci_ctrl_i.transmit_enable && !sci_ctrl_i.rx_on
            |=> serial_status_o == SCI_STAT_RST;
    endproperty
    a_te_rst: assert property (p_te_rst) else $error("status kept");
    property p_port;
        sci_module_stop_i |=> txd_o == $past(port_txd_level_i);
    endproperty
    a_port: assert property (p_port) else $error("txd not port");
    property p_oe_run;
        mode_o != PM_DEEP && dac_ctrl_i.dac_output_enable_0 |=> dac_oe_0_o;
    endproperty
    a_oe_run: assert property (p_oe_run) else $error("dac oe low");
    c_deep: cover property (mode_o == PM_DEEP);
    c_port: cover property (sci_module_stop_i && !txd_o);
    c_te: cover property (!sci_ctrl_i.transmit_enable ##1 txd_o);
endmodule : lpe_top_monitor

bind lpe_top lpe_top_monitor lpe_top_monitor_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wait_exec_i(wait_exec_i),
    .standby_select_i(standby_select_i),
    .deep_standby_select_i(deep_standby_select_i),
    .ext_bus_enable_i(ext_bus_enable_i),
    .bus_clock_output_stop_i(bus_clock_output_stop_i),
    .dac_ctrl_i(dac_ctrl_i), .sci_ctrl_i(sci_ctrl_i),
    .sci_module_stop_i(sci_module_stop_i),
    .port_txd_level_i(port_txd_level_i), .mode_o(mode_o),
    .external_bus_clock_o(external_bus_clock_o),
    .dac_out_0_o(dac_out_0_o), .dac_oe_0_o(dac_oe_0_o),
    .dac_analog_current_o(dac_analog_current_o), .txd_o(txd_o),
    .serial_status_o(serial_status_o)
);

/* File: verif/lpe_top_tb_top.sv */
// self-checking bench for the low power entry block
`timescale 1ns/1ps
module lpe_top_tb_top
    import lpe_pkg::*;
;
    logic sys_clk_i, rst_i, wait_exec_i, wake_i, standby_select_i;
    logic deep_standby_select_i, all_module_stop_select_i, ext_bus_enable_i;
    logic bus_clock_output_stop_i, dac_module_stop_i, adc_module_stop_i;
    logic adc_conversion_start_i, sci_module_stop_i, tx_write_i, rx_read_i;
    logic rxd_i, port_txd_level_i, external_bus_clock_o, dac_oe_0_o;
    logic dac_oe_1_o, dac_analog_current_o, adc_analog_current_o, txd_o;
    logic rx_valid_o;
    logic [DAC_W-1:0] dac_data_0_i, dac_data_1_i, dac_out_0_o, dac_out_1_o;
    logic [SCI_W-1:0] tx_data_i, rx_data_o;
    lpe_dac_ctrl_t dac_ctrl_i;
    lpe_sci_ctrl_t sci_ctrl_i;
    lpe_pm_t mode_o;
    lpe_sci_stat_t serial_status_o;
    int num_errors = 0;
    int n_tests = 0;
    int n_rxv = 0;

    lpe_top lpe_top_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wait_exec_i(wait_exec_i),
        .wake_i(wake_i), .standby_select_i(standby_select_i),
        .deep_standby_select_i(deep_standby_select_i),
        .all_module_stop_select_i(all_module_stop_select_i),
        .ext_bus_enable_i(ext_bus_enable_i),
        .bus_clock_output_stop_i(bus_clock_output_stop_i),
        .dac_ctrl_i(dac_ctrl_i), .dac_module_stop_i(dac_module_stop_i),
        .dac_data_0_i(dac_data_0_i), .dac_data_1_i(dac_data_1_i),
        .adc_conversion_start_i(adc_conversion_start_i),
        .adc_module_stop_i(adc_module_stop_i), .sci_ctrl_i(sci_ctrl_i),
        .sci_module_stop_i(sci_module_stop_i), .tx_data_i(tx_data_i),
        .tx_write_i(tx_write_i), .rx_read_i(rx_read_i), .rxd_i(rxd_i),
        .port_txd_level_i(port_txd_level_i), .mode_o(mode_o),
        .external_bus_clock_o(external_bus_clock_o),
        .dac_out_0_o(dac_out_0_o), .dac_out_1_o(dac_out_1_o),
        .dac_oe_0_o(dac_oe_0_o), .dac_oe_1_o(dac_oe_1_o),
        .dac_analog_current_o(dac_analog_current_o),
        .adc_analog_current_o(adc_analog_current_o), .txd_o(txd_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .serial_status_o(serial_status_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (rx_valid_o === 1'b1) n_rxv++;
    end
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic complete_run;
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic count_bclk(input int n, output int ch);
        logic prev;
        ch = 0;
        prev = external_bus_clock_o;
        repeat (n) begin
            step(1);
            if (external_bus_clock_o !== prev) ch++;
            prev = external_bus_clock_o;
        end
    endtask : count_bclk
    task automatic enter(input logic [2:0] sel);
        {standby_select_i, deep_standby_select_i,
            all_module_stop_select_i} = sel;
        // dma and transfer units sit outside, taken as already stopped
        wait_exec_i = 1'b1;
        step(1);
        wait_exec_i = 1'b0;
    endtask : enter
    task automatic leave;
        wake_i = 1'b1;
        step(1);
        wake_i = 1'b0;
        step(1);
    endtask : leave
    task automatic tx_put(input logic [7:0] d);
        tx_data_i = d;
        tx_write_i = 1'b1;
        step(1);
        tx_write_i = 1'b0;
    endtask : tx_put
    ////////////////////////////////////////
    task automatic t_modes;
        logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h6};
        lpe_pm_t em [5] = '{PM_SLEEP, PM_SLEEP, PM_ALLSTOP, PM_SWSTBY,
            PM_DEEP};
        int ch;
        logic sb;
        logic dp;
        logic bc_ok;
        for (int i = 0; i < 5; i++) begin
            dac_data_0_i = 8'h5a;
            step(2);
            check(dac_out_0_o, 8'h5a);
            check(8'(dac_oe_1_o), 8'h1);
            enter(sel[i]);
            check(8'(mode_o), 8'(em[i]));
            dp = (em[i] == PM_DEEP);
            sb = dp || (em[i] == PM_SWSTBY);
            dac_data_0_i = 8'ha5;
            step(3);
            check(dac_out_0_o, (em[i] == PM_SLEEP) ? 8'ha5 : 8'h5a);
            check(8'(dac_oe_0_o), 8'(!dp));
            check(8'(dac_analog_current_o), 8'(!dp));
            count_bclk(12, ch);
            bc_ok = sb ? (ch == 0 && external_bus_clock_o) : ch >= 5;
            check(8'(bc_ok), 8'h1);
            leave;
        end
    endtask : t_modes
    // conversion current survives module stop until software clears start
    task automatic t_analog;
        adc_module_stop_i = 1'b1;
        step(2);
        check(8'(adc_analog_current_o), 8'h1);
        check(dac_out_1_o, 8'hc3);
        adc_conversion_start_i = 1'b0;
        dac_ctrl_i = '0;
        enter(3'h4);
        dac_data_1_i = 8'h3c;
        step(2);
        check(8'(adc_analog_current_o), 8'h0);
        check(8'(dac_analog_current_o), 8'h0);
        check(dac_out_1_o, 8'hc3);
        leave;
        check(dac_out_1_o, 8'h3c);
    endtask : t_analog
    task automatic t_pstop;
        int ch;
        bus_clock_output_stop_i = 1'b1;
        step(2);
        count_bclk(10, ch);
        check(8'(ch == 0 && external_bus_clock_o), 8'h1);
        bus_clock_output_stop_i = 1'b0;
        count_bclk(12, ch);
        check(8'(ch >= 5), 8'h1);
    endtask : t_pstop
    // second byte fills the holding register behind the shifter
    task automatic t_tx_te;
        sci_ctrl_i.transmit_enable = 1'b1;
        tx_put(8'h3c);
        step(40);
        tx_put(8'hc3);
        step(2);
        check(8'(serial_status_o.tx_empty), 8'h0);
        sci_ctrl_i.transmit_enable = 1'b0;
        step(1);
        check(8'(serial_status_o), 8'(SCI_STAT_RST));
        check(8'(txd_o), 8'h1);
        step(2);
    endtask : t_tx_te
    task automatic t_port;
        sci_module_stop_i = 1'b1;
        step(2);
        check(8'(txd_o), 8'h0);
        port_txd_level_i = 1'b1;
        step(2);
        check(8'(txd_o), 8'h1);
        port_txd_level_i = 1'b0;
        step(1);
        sci_module_stop_i = 1'b0;
        step(2);
        check(8'(txd_o), 8'h1);
    endtask : t_port
    // upper bits stay high so an aborted frame cannot restart
    task automatic rx_frame(input logic [7:0] d, input int lp_at);
        rxd_i = 1'b0;
        step(16);
        for (int i = 0; i < 8; i++) begin
            rxd_i = d[i];
            if (i == lp_at) begin
                enter(3'h0);
                step(15);
            end else begin
                step(16);
            end
        end
        rxd_i = 1'b1;
        step(48);
    endtask : rx_frame
    task automatic t_rx;
        int base;
        // sleep entry only, so both serial enables may stay on
        sci_ctrl_i = 4'h6;
        base = n_rxv;
        rx_frame(8'ha3, 9);
        check(rx_data_o, 8'ha3);
        check(8'(n_rxv - base), 8'h1);
        check(8'(serial_status_o.rx_full), 8'h1);
        rx_read_i = 1'b1;
        step(1);
        rx_read_i = 1'b0;
        rx_frame(8'hf0, 4);
        check(8'(serial_status_o.rx_full), 8'h0);
        check(8'(n_rxv - base), 8'h1);
        check(rx_data_o, 8'ha3);
        leave;
    endtask : t_rx
    ////////////////////////////////////////
    initial begin
        {wait_exec_i, wake_i, standby_select_i, deep_standby_select_i} = '0;
        {all_module_stop_select_i, bus_clock_output_stop_i, tx_write_i} = '0;
        {dac_module_stop_i, adc_module_stop_i, sci_module_stop_i} = '0;
        {rx_read_i, port_txd_level_i, dac_data_0_i, tx_data_i} = '0;
        {rst_i, ext_bus_enable_i, adc_conversion_start_i, rxd_i} = 4'hf;
        dac_data_1_i = 8'hc3;
        dac_ctrl_i = 3'h7;
        sci_ctrl_i = 4'h0;
        step(3);
        rst_i = 1'b0;
        step(1);
        t_modes();
        t_analog();
        t_pstop();
        t_tx_te();
        t_port();
        t_rx();
        complete_run();
    end
    initial begin
        #50000;
        num_errors++;
        complete_run();
    end
endmodule : lpe_top_tb_top
